// File: rtl/dfpg_pkg.sv
// constants, types and register map of the drive fault and parameter guard
// assumes one 100 MHz clock and an Avalon-MM master on the register side
// How it works
// - a live fault lights the fault led, shows its code and stops the drive
// - keypad press, start input falling, or supply restore clears an active fault
// - start still active at the clear runs the drive with no new edge
// - codes flagged power only clear only on a supply restore
// - every latched fault is recorded in a history of three entries
// - reading the history never changes it
// - a new record on a full history drops the oldest entry
// - undervoltage with auto restart records only if still present after the wait
// - both clear buttons while reviewing wipe all three history entries
// - lock engaged rejects parameter writes except frequency and local reference
// - lock open accepts parameter writes
// - setpoint holds 0.0 to 100.0, edited only in local mode
// - a read only register shows the software version
// - select value 1 ignores the alternate set whatever input five does
// - code 1 means no fault, seen only in the history, never live
package dfpg_pkg;
   // ***************************************************************
   // timing and codes
   // ***************************************************************
   localparam int         CLK_MHZ         = 100;
   localparam int         RESTART_WAIT_US = 10;
   localparam int         RESTART_CYC     = RESTART_WAIT_US * CLK_MHZ;
   localparam int         RWAIT_W         = $clog2(RESTART_CYC);
   localparam int         CODE_W          = 4;
   localparam int         HIST_DEPTH      = 3;
   localparam logic [3:0] CODE_NONE       = 4'h0;
   localparam logic [3:0] CODE_NO_FAULT   = 4'h1;
   localparam logic [3:0] CODE_FIRST_LIVE = 4'h2;
   localparam logic [3:0] CODE_UNDERVOLT  = 4'h3;
   localparam logic [15:0] SETPOINT_MAX   = 16'h03e8;
   localparam logic [1:0] SEL_PRIMARY     = 2'h1;
   localparam logic [1:0] SEL_ALT         = 2'h2;
   // ***************************************************************
   // register byte offsets
   // ***************************************************************
   localparam logic [5:0] OFS_STATUS   = 6'h00;
   localparam logic [5:0] OFS_MASK     = 6'h04;
   localparam logic [5:0] OFS_CTRL     = 6'h08;
   localparam logic [5:0] OFS_FAULT    = 6'h0c;
   localparam logic [5:0] OFS_HIST     = 6'h10;
   localparam logic [5:0] OFS_LOCK     = 6'h14;
   localparam logic [5:0] OFS_OUTF     = 6'h18;
   localparam logic [5:0] OFS_LOCREF   = 6'h1c;
   localparam logic [5:0] OFS_SETSEL   = 6'h20;
   localparam logic [5:0] OFS_SETPOINT = 6'h24;
   localparam logic [5:0] OFS_VERSION  = 6'h28;
   localparam logic [5:0] OFS_PWRMASK  = 6'h2c;
   // ***************************************************************
   // event bits, pin slots, reset values
   // ***************************************************************
   localparam int EV_LATCH = 0;
   localparam int EV_CLEAR = 1;
   localparam int EV_REJECT = 2;
   localparam int EV_HCLR = 3;
   localparam int EV_W = 4;
   localparam int PIN_START = 0;
   localparam int PIN_DI5 = 1;
   localparam int PIN_KEYPAD = 2;
   localparam int PIN_CLR_A = 3;
   localparam int PIN_CLR_B = 4;
   localparam int PIN_REVIEW = 5;
   localparam int PIN_REMOTE = 6;
   localparam int PIN_SUPPLY = 7;
   localparam int PIN_W = 8;
   localparam logic [15:0] PWRMASK_RST = 16'h0000;
   typedef enum logic [1:0] {ST_OK, ST_UV_WAIT, ST_FAULT} dfpg_st_t;
   typedef logic [HIST_DEPTH-1:0][CODE_W-1:0] dfpg_hist_t;
   typedef struct packed {
      logic [5:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } dfpg_avs_req_t;
   typedef struct packed {
      dfpg_st_t           st;
      logic [CODE_W-1:0]  code;
      logic               pwr_only;
      logic [RWAIT_W-1:0] rwait;
      logic [PIN_W-1:0]   pin_prev;
      logic               both_prev;
      logic [EV_W-1:0]    irq_st;
      logic [EV_W-1:0]    mask;
      logic               autorst;
      logic               lock;
      logic [15:0]        outf;
      logic [15:0]        locref;
      logic [15:0]        setpoint;
      logic [15:0]        pwrmask;
      logic [1:0]         setsel;
      logic               wait_r;
      logic [31:0]        rdata;
      logic               irq;
      logic               led;
      logic               run;
      logic               alt;
      logic [CODE_W-1:0]  shown;
      logic               hrec;
      logic [CODE_W-1:0]  hcode;
      logic               hclr;
   } dfpg_top_st_t;
endpackage : dfpg_pkg

// File: rtl/dfpg_sync.sv
// two flop synchroniser for a group of pin inputs
// assumes each bit is an independent level; no bus coherence between bits
`timescale 1ns/1ps
module dfpg_sync #(
   parameter int W = 8
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic [W-1:0]      dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dfpg_sync_st_t;
   dfpg_sync_st_t q;
   dfpg_sync_st_t d;
   always_comb
   begin
      d    = q;
      d.s1 = din;
      d.s2 = q.s1;
   end
   always_ff @(posedge mclk)
   begin
      if (rst)
         q <= '0;
      else
         q <= d;
   end
   assign dout = q.s2;
endmodule : dfpg_sync

// File: rtl/dfpg_hist.sv
// fault history: newest entry at index 0, empty slots hold the no fault code
// assumes rec and clr are single cycle pulses from the same clock
`timescale 1ns/1ps
module dfpg_hist #(
   parameter int DEPTH = dfpg_pkg::HIST_DEPTH
) (
   input  wire logic                            mclk,
   input  wire logic                            rst,
   input  wire logic                            rec,
   input  wire logic [dfpg_pkg::CODE_W-1:0]     rec_code,
   input  wire logic                            clr,
   output logic [DEPTH-1:0][dfpg_pkg::CODE_W-1:0] entries
);
   typedef struct packed {
      logic [DEPTH-1:0][dfpg_pkg::CODE_W-1:0] ent;
   } dfpg_hist_st_t;
   dfpg_hist_st_t q;
   dfpg_hist_st_t d;
   // ***************************************************************
   // record and wipe
   // ***************************************************************
   always_comb
   begin
      d = q;
      if (clr)
         d.ent = {DEPTH{dfpg_pkg::CODE_NO_FAULT}};
      // recording after a wipe keeps the new fault: set beats clear
      if (rec)
      begin
         for (int i = DEPTH - 1; i > 0; i--)
            d.ent[i] = d.ent[i-1];
         d.ent[0] = rec_code;
      end
   end
   always_ff @(posedge mclk)
   begin
      if (rst)
         q <= {DEPTH{dfpg_pkg::CODE_NO_FAULT}};
      else
         q <= d;
   end
   assign entries = q.ent;
   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   hist_push_a: assert property (rec && !clr |=> q.ent[0] == $past(rec_code)
      && q.ent[DEPTH-1] == $past(q.ent[DEPTH-2]))
      else $error("history did not push the new fault");
   hist_hold_a: assert property (!rec && !clr |=> $stable(q.ent))
      else $error("history changed without a record or wipe");
   hist_clear_a: assert property (clr && !rec |=> q.ent == {DEPTH{dfpg_pkg::CODE_NO_FAULT}})
      else $error("history wipe left an entry");
   hist_full_c: cover property (rec && q.ent[DEPTH-1] != dfpg_pkg::CODE_NO_FAULT);
endmodule : dfpg_hist

// File: rtl/dfpg_top.sv
// fault latch, reset sources, parameter guard and register file of the drive
// assumes fault_code comes from on-chip monitors on mclk; panel pins are async
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module dfpg_top #(
   parameter logic [31:0] SW_VERSION  = 32'h0000_0102, // arbitrary value
   parameter int          RESTART_CYC = dfpg_pkg::RESTART_CYC
) (
   input  wire logic                        mclk,
   input  wire logic                        rst,
   input  wire dfpg_pkg::dfpg_avs_req_t     avs,
   output logic [31:0]                      avs_readdata,
   output logic                             avs_waitrequest,
   output logic                             irq,
   input  wire logic [dfpg_pkg::CODE_W-1:0] fault_code,
   input  wire logic                        start_input_terminal,
   input  wire logic                        digital_input_five,
   input  wire logic                        keypad_reset,
   input  wire logic                        clear_btn_a,
   input  wire logic                        clear_btn_b,
   input  wire logic                        review_active,
   input  wire logic                        remote_mode,
   input  wire logic                        supply_ok,
   output logic                             drive_run,
   output logic                             fault_led,
   output logic                             alt_set_active,
   output logic [dfpg_pkg::CODE_W-1:0]      fault_shown
);
   localparam int            RW         = dfpg_pkg::RWAIT_W;
   localparam logic [RW-1:0] RWAIT_LAST = RW'(RESTART_CYC - 1);

   dfpg_pkg::dfpg_top_st_t   q;
   dfpg_pkg::dfpg_top_st_t   d;
   logic [dfpg_pkg::PIN_W-1:0] pin_raw;
   logic [dfpg_pkg::PIN_W-1:0] pin_s;
   dfpg_pkg::dfpg_hist_t     hist_ent;
   logic                     kp_pulse;
   logic                     start_fall;
   logic                     pwr_restore;
   logic                     live_valid;
   logic                     uv_defer;
   logic                     clr_req;
   logic                     both;
   logic                     wr;

   // ***************************************************************
   // pin synchronisation and edges
   // ***************************************************************
   assign pin_raw = {supply_ok, remote_mode, review_active, clear_btn_b,
                     clear_btn_a, keypad_reset, digital_input_five, start_input_terminal};

   dfpg_sync #(
      .W    (dfpg_pkg::PIN_W)
   ) u_sync (
      .mclk (mclk),
      .rst  (rst),
      .din  (pin_raw),
      .dout (pin_s)
   );

   assign kp_pulse    = pin_s[dfpg_pkg::PIN_KEYPAD] & ~q.pin_prev[dfpg_pkg::PIN_KEYPAD];
   assign start_fall  = ~pin_s[dfpg_pkg::PIN_START] & q.pin_prev[dfpg_pkg::PIN_START];
   assign pwr_restore = pin_s[dfpg_pkg::PIN_SUPPLY] & ~q.pin_prev[dfpg_pkg::PIN_SUPPLY];
   // codes 0 and 1 never trip
   assign live_valid  = fault_code >= dfpg_pkg::CODE_FIRST_LIVE;
   assign uv_defer    = (fault_code == dfpg_pkg::CODE_UNDERVOLT) && q.autorst;
   // power only codes ignore panel and start resets
   assign clr_req     = pwr_restore || (!q.pwr_only && (kp_pulse || start_fall));
   assign both        = pin_s[dfpg_pkg::PIN_CLR_A] & pin_s[dfpg_pkg::PIN_CLR_B]
                        & pin_s[dfpg_pkg::PIN_REVIEW];
   // a write lands only at the edge where waitrequest is seen low
   assign wr          = avs.write && !q.wait_r;

   dfpg_hist #(
      .DEPTH    (dfpg_pkg::HIST_DEPTH)
   ) u_hist (
      .mclk     (mclk),
      .rst      (rst),
      .rec      (q.hrec),
      .rec_code (q.hcode),
      .clr      (q.hclr),
      .entries  (hist_ent)
   );

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb
   begin
      logic                  trip;
      logic                  rej;
      logic [dfpg_pkg::EV_W-1:0] ev;
      logic [dfpg_pkg::EV_W-1:0] w1c;
      trip       = 1'b0;
      rej        = 1'b0;
      ev         = '0;
      w1c        = '0;
      d          = q;
      d.hrec     = 1'b0;
      d.hclr     = 1'b0;
      d.pin_prev = pin_s;
      d.both_prev = both;

      unique case (q.st)
         dfpg_pkg::ST_OK:
         begin
            if (live_valid)
            begin
               if (uv_defer)
               begin
                  d.st    = dfpg_pkg::ST_UV_WAIT;
                  d.rwait = '0;
               end
               else
                  trip = 1'b1;
            end
         end
         dfpg_pkg::ST_UV_WAIT:
         begin
            // gone or replaced: back to ok, a new code trips next cycle
            if (fault_code != dfpg_pkg::CODE_UNDERVOLT)
               d.st = dfpg_pkg::ST_OK;
            else if (q.rwait == RWAIT_LAST)
               trip = 1'b1;
            else
               d.rwait = q.rwait + 1'b1;
         end
         dfpg_pkg::ST_FAULT:
         begin
            if (clr_req)
            begin
               d.st = dfpg_pkg::ST_OK;
               ev[dfpg_pkg::EV_CLEAR] = 1'b1;
            end
         end
         default:
            d.st = dfpg_pkg::ST_OK;
      endcase

      if (trip)
      begin
         d.st       = dfpg_pkg::ST_FAULT;
         d.code     = fault_code;
         d.pwr_only = q.pwrmask[fault_code];
         d.hrec     = 1'b1;
         d.hcode    = fault_code;
         ev[dfpg_pkg::EV_LATCH] = 1'b1;
      end

      if (both && !q.both_prev)
      begin
         d.hclr = 1'b1;
         ev[dfpg_pkg::EV_HCLR] = 1'b1;
      end

      // bus slave: one wait cycle, then complete
      d.wait_r = 1'b1;
      if ((avs.read || avs.write) && q.wait_r)
      begin
         d.wait_r = 1'b0;
         case (avs.address)
            dfpg_pkg::OFS_STATUS:   d.rdata = 32'(q.irq_st);
            dfpg_pkg::OFS_MASK:     d.rdata = 32'(q.mask);
            dfpg_pkg::OFS_CTRL:     d.rdata = 32'(q.autorst);
            dfpg_pkg::OFS_FAULT:    d.rdata = 32'({q.pwr_only, q.code, q.alt, q.run, q.led});
            dfpg_pkg::OFS_HIST:     d.rdata = 32'(hist_ent);
            dfpg_pkg::OFS_LOCK:     d.rdata = 32'(q.lock);
            dfpg_pkg::OFS_OUTF:     d.rdata = 32'(q.outf);
            dfpg_pkg::OFS_LOCREF:   d.rdata = 32'(q.locref);
            dfpg_pkg::OFS_SETSEL:   d.rdata = 32'(q.setsel);
            dfpg_pkg::OFS_SETPOINT: d.rdata = 32'(q.setpoint);
            dfpg_pkg::OFS_VERSION:  d.rdata = SW_VERSION;
            dfpg_pkg::OFS_PWRMASK:  d.rdata = 32'(q.pwrmask);
            default:                d.rdata = '0;
         endcase
      end

      if (wr)
      begin
         case (avs.address)
            dfpg_pkg::OFS_STATUS: w1c = avs.writedata[dfpg_pkg::EV_W-1:0];
            dfpg_pkg::OFS_MASK:   d.mask = avs.writedata[dfpg_pkg::EV_W-1:0];
            // the lock itself stays writable, else it could never open
            dfpg_pkg::OFS_LOCK:   d.lock = avs.writedata[0];
            dfpg_pkg::OFS_OUTF:   d.outf = avs.writedata[15:0];
            dfpg_pkg::OFS_LOCREF: d.locref = avs.writedata[15:0];
            dfpg_pkg::OFS_CTRL:
            begin
               if (q.lock)
                  rej = 1'b1;
               else
                  d.autorst = avs.writedata[0];
            end
            dfpg_pkg::OFS_SETSEL:
            begin
               if (q.lock || (avs.writedata != 32'(dfpg_pkg::SEL_PRIMARY)
                              && avs.writedata != 32'(dfpg_pkg::SEL_ALT)))
                  rej = 1'b1;
               else
                  d.setsel = avs.writedata[1:0];
            end
            dfpg_pkg::OFS_SETPOINT:
            begin
               // remote mode shows the setpoint but never takes an edit
               if (q.lock || pin_s[dfpg_pkg::PIN_REMOTE]
                   || avs.writedata > 32'(dfpg_pkg::SETPOINT_MAX))
                  rej = 1'b1;
               else
                  d.setpoint = avs.writedata[15:0];
            end
            dfpg_pkg::OFS_PWRMASK:
            begin
               if (q.lock)
                  rej = 1'b1;
               else
                  d.pwrmask = avs.writedata[15:0];
            end
            default: ;
         endcase
      end
      ev[dfpg_pkg::EV_REJECT] = rej;

      // a new event wins over a write one clear in the same cycle
      d.irq_st = (q.irq_st & ~w1c) | ev;
      d.irq    = |(d.irq_st & d.mask);

      // run follows the start level, so no fresh edge is needed
      d.run   = (d.st == dfpg_pkg::ST_OK) && pin_s[dfpg_pkg::PIN_START]
                && pin_s[dfpg_pkg::PIN_SUPPLY];
      d.led   = d.st == dfpg_pkg::ST_FAULT;
      d.shown = d.led ? d.code : dfpg_pkg::CODE_NONE;
      d.alt   = (q.setsel == dfpg_pkg::SEL_ALT) && pin_s[dfpg_pkg::PIN_DI5];
   end

   // ***************************************************************
   // state register
   // ***************************************************************
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         q          <= '0;
         q.st       <= dfpg_pkg::ST_OK;
         q.setsel   <= dfpg_pkg::SEL_PRIMARY;
         q.pwrmask  <= dfpg_pkg::PWRMASK_RST;
         q.wait_r   <= 1'b1;
         q.hcode    <= dfpg_pkg::CODE_NONE;
      end
      else
         q <= d;
   end

   assign avs_readdata    = q.rdata;
   assign avs_waitrequest = q.wait_r;
   assign irq             = q.irq;
   assign drive_run       = q.run;
   assign fault_led       = q.led;
   assign alt_set_active  = q.alt;
   assign fault_shown     = q.shown;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   fault_latch_a: assert property (q.st == dfpg_pkg::ST_OK && live_valid && !uv_defer
      |=> fault_led && !drive_run && fault_shown == $past(fault_code))
      else $error("live fault not latched");
   reset_clear_a: assert property (q.st == dfpg_pkg::ST_FAULT && !q.pwr_only && kp_pulse
      |=> !fault_led)
      else $error("keypad press did not clear fault");
   relatch_a: assert property (q.st == dfpg_pkg::ST_FAULT && clr_req && live_valid
      && !uv_defer ##1 live_valid && !uv_defer |=> fault_led)
      else $error("persisting fault did not trip again");
   restart_run_a: assert property (q.st == dfpg_pkg::ST_FAULT && clr_req
      && pin_s[dfpg_pkg::PIN_START] && pin_s[dfpg_pkg::PIN_SUPPLY] |=> drive_run)
      else $error("drive did not start after clear");
   pwr_hold_a: assert property (q.st == dfpg_pkg::ST_FAULT && q.pwr_only && !pwr_restore
      |=> fault_led)
      else $error("power only fault cleared early");
   uv_defer_a: assert property (q.st == dfpg_pkg::ST_OK && uv_defer
      |=> q.st == dfpg_pkg::ST_UV_WAIT && !fault_led && !q.hrec)
      else $error("undervoltage recorded before restart wait");
   lock_reject_a: assert property (wr && q.lock && avs.address == dfpg_pkg::OFS_SETSEL
      |=> $stable(q.setsel) && q.irq_st[dfpg_pkg::EV_REJECT])
      else $error("lock_engaged write changed a parameter");
   open_accept_a: assert property (wr && !q.lock && avs.address == dfpg_pkg::OFS_PWRMASK
      |=> q.pwrmask == $past(avs.writedata[15:0]))
      else $error("open lock write not taken");
   setpoint_range_a: assert property (q.setpoint <= dfpg_pkg::SETPOINT_MAX)
      else $error("setpoint out of range");
   alt_set_a: assert property (alt_set_active == ($past(q.setsel) == dfpg_pkg::SEL_ALT
      && $past(pin_s[dfpg_pkg::PIN_DI5])))
      else $error("alternate set select wrong");
   primary_set_a: assert property (q.setsel == dfpg_pkg::SEL_PRIMARY ##1
      q.setsel == dfpg_pkg::SEL_PRIMARY |-> !alt_set_active)
      else $error("alternate set used with select 1");
   version_ro_a: assert property (q.wait_r && avs.read && avs.address == dfpg_pkg::OFS_VERSION
      |=> avs_readdata == SW_VERSION && !avs_waitrequest)
      else $error("version read wrong");

   trip_c: cover property (q.st == dfpg_pkg::ST_OK && live_valid ##1 fault_led);
   run_after_c: cover property (fault_led ##1 !fault_led && drive_run);
   uv_ride_c: cover property (q.st == dfpg_pkg::ST_UV_WAIT ##1 q.st == dfpg_pkg::ST_OK);
   wipe_c: cover property (q.hclr);
endmodule : dfpg_top

// File: verif/dfpg_panel.sv
// operator panel keypad and control terminal pin model
// assumes the bench calls its tasks from one process only
`timescale 1ns/1ps
module dfpg_panel (
   input  wire logic  mclk,
   output logic [6:0] pins
);
   // ****
   // pins: start di5 keypad clr_a clr_b review supply
   // ****
   initial pins = 7'h41;
   task automatic flip(input logic [6:0] m);
      @(posedge mclk);
      pins <= pins ^ m;
   endtask : flip
   // six cycles, so the two sync flops surely catch it
   task automatic pulse(input logic [6:0] m);
      flip(m);
      repeat (6) @(posedge mclk);
      pins <= pins ^ m;
   endtask : pulse
endmodule : dfpg_panel

// File: verif/test_dfpg_top.sv
// self-checking bench of the drive fault and parameter guard
// assumes dfpg_panel drives the pins; remote mode driven by the bench
`timescale 1ns/1ps
module test_dfpg_top;
   logic                    mclk, rst, wreq, irq, run, led, alt;
   logic [31:0]             rdat, rq;
   logic [3:0]              shown, fcode;
   logic [6:0]              pins;
   logic                    remote;
   dfpg_pkg::dfpg_avs_req_t avs;
   int                      err_total, cmp_count;
   dfpg_panel panel (.mclk(mclk), .pins(pins));
   // short restart wait keeps the run brief
   dfpg_top #(.RESTART_CYC(8)) DUT (.mclk(mclk), .rst(rst), .avs(avs),
      .avs_readdata(rdat), .avs_waitrequest(wreq), .irq(irq), .fault_code(fcode),
      .start_input_terminal(pins[6]), .digital_input_five(pins[5]),
      .keypad_reset(pins[4]), .clear_btn_a(pins[3]), .clear_btn_b(pins[2]),
      .review_active(pins[1]), .remote_mode(remote), .supply_ok(pins[0]),
      .drive_run(run), .fault_led(led), .alt_set_active(alt), .fault_shown(shown));
   // ****
   // helpers
   // ****
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc
   // monitor code changes only at a rising edge
   task automatic setf(input logic [3:0] c);
      @(posedge mclk);
      fcode <= c;
   endtask : setf
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs <= '{a, !w, w, d};
      @(posedge mclk);
      // no cycle count assumed: only the watchdog ends a hung wait
      while (wreq !== 1'b0)
         @(posedge mclk);
      rq = rdat;
      avs <= '0;
   endtask : bus
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rq, e);
   endtask : rd
   task automatic wrap_up();
      $display("checks %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   // ****
   // scenarios
   // ****
   task automatic t_trip();
      bus(1'b1, dfpg_pkg::OFS_MASK, 32'h1);
      chk({irq, run}, 2'h1);
      fcode <= 4'h4;
      cyc(6);
      chk({irq, led, run, shown}, 7'h64);
      rd(dfpg_pkg::OFS_HIST, 32'h114);
      fcode <= 4'h0;
      panel.pulse(7'h10);
      cyc(4);
      chk({led, run}, 2'h1);
      bus(1'b1, dfpg_pkg::OFS_STATUS, 32'hf);
      cyc(2);
      chk(irq, 1'b0);
      $display("trip test done");
   endtask : t_trip
   task automatic t_hist();
      setf(4'h5);
      cyc(5);
      panel.pulse(7'h10);
      cyc(5);
      chk(led, 1'b1);
      rd(dfpg_pkg::OFS_HIST, 32'h455);
      fcode <= 4'h6;
      panel.pulse(7'h10);
      cyc(5);
      rd(dfpg_pkg::OFS_HIST, 32'h556);
      rd(dfpg_pkg::OFS_HIST, 32'h556);
      fcode <= 4'h0;
      panel.pulse(7'h10);
      $display("history test done");
   endtask : t_hist
   task automatic t_power();
      bus(1'b1, dfpg_pkg::OFS_PWRMASK, 32'h80);
      fcode <= 4'h7;
      cyc(5);
      setf(4'h0);
      panel.pulse(7'h10);
      panel.pulse(7'h40);
      cyc(5);
      chk(led, 1'b1);
      panel.pulse(7'h01);
      cyc(5);
      chk(led, 1'b0);
      panel.pulse(7'h0e);
      cyc(4);
      rd(dfpg_pkg::OFS_HIST, 32'h111);
      $display("power and wipe test done");
   endtask : t_power
   task automatic t_uv();
      bus(1'b1, dfpg_pkg::OFS_CTRL, 32'h1);
      fcode <= 4'h1;
      cyc(4);
      chk(led, 1'b0);
      setf(4'h3);
      cyc(4);
      setf(4'h0);
      cyc(3);
      chk(led, 1'b0);
      rd(dfpg_pkg::OFS_HIST, 32'h111);
      setf(4'h3);
      cyc(12);
      chk({led, shown}, 5'h13);
      rd(dfpg_pkg::OFS_HIST, 32'h113);
      fcode <= 4'h0;
      panel.pulse(7'h10);
      cyc(4);
      chk(led, 1'b0);
      $display("undervoltage test done");
   endtask : t_uv
   task automatic t_param();
      bus(1'b1, dfpg_pkg::OFS_LOCK, 32'h1);
      bus(1'b1, dfpg_pkg::OFS_SETSEL, 32'h2);
      rd(dfpg_pkg::OFS_SETSEL, 32'h1);
      bus(1'b1, dfpg_pkg::OFS_OUTF, 32'h1234);
      rd(dfpg_pkg::OFS_OUTF, 32'h1234);
      bus(1'b1, dfpg_pkg::OFS_LOCK, 32'h0);
      bus(1'b1, dfpg_pkg::OFS_SETPOINT, 32'h3e9);
      rd(dfpg_pkg::OFS_SETPOINT, 32'h0);
      bus(1'b1, dfpg_pkg::OFS_SETPOINT, 32'h3e8);
      rd(dfpg_pkg::OFS_SETPOINT, 32'h3e8);
      bus(1'b1, dfpg_pkg::OFS_SETPOINT, 32'h320);
      remote <= 1'b1;
      cyc(4);
      bus(1'b1, dfpg_pkg::OFS_SETPOINT, 32'h64);
      rd(dfpg_pkg::OFS_SETPOINT, 32'h320);
      remote <= 1'b0;
      bus(1'b1, dfpg_pkg::OFS_SETSEL, 32'h2);
      panel.flip(7'h20);
      cyc(5);
      chk(alt, 1'b1);
      bus(1'b1, dfpg_pkg::OFS_SETSEL, 32'h1);
      cyc(3);
      chk(alt, 1'b0);
      rd(dfpg_pkg::OFS_VERSION, 32'h102);
      rd(6'h30, 32'h0);
      $display("parameter test done");
   endtask : t_param
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // ample: the whole run needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge mclk);
      err_total++;
      wrap_up();
   end
   initial
   begin
      err_total = 0;
      cmp_count = 0;
      avs = '0;
      fcode = 4'h0;
      remote = 1'b0;
      rst = 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      cyc(6);
      t_trip();
      t_hist();
      t_power();
      t_uv();
      t_param();
      wrap_up();
   end
endmodule : test_dfpg_top
